// [pkg/wdt_defines.svh]
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH

// register addresses on the special-function bus
`define WDT_CTRL_ADDR        8'hA7
`define WDT_FEED_ADDR        8'hA6
`define WDT_IRQ_STAT_ADDR    8'hA8
`define WDT_IRQ_MASK_ADDR    8'hA9

// control register field positions
`define WDT_OVF_BIT          5
`define WDT_RUN_BIT          4
`define WDT_CLKSEL_BIT       3
`define WDT_RATE_MSB         2
`define WDT_RATE_LSB         0

// control register reset values
`define WDT_CTRL_RST_WDOG    8'h30
`define WDT_CTRL_RST_EN      8'h10
`define WDT_CTRL_RST_DIS     8'h00
`define WDT_CTRL_WMASK       8'h1F

// interrupt status and mask bit positions
`define WDT_IRQ_OVF_BIT      0
`define WDT_IRQ_FEED_BIT     1
`define WDT_IRQ_RST          8'h00

// feed sequence values
`define WDT_FEED_FIRST       8'h1E
`define WDT_FEED_SECOND      8'hE1

// timeout length for rate code zero, in count clocks
`define WDT_BASE_TIMEOUT     20'h02000

// count clock divider and init settle time
`define WDT_CPU_DIV_LAST     3'h5
`define WDT_INIT_LOAD        2'h2
`define WDT_INIT_DONE        2'h3

// internal reset pulse length
`define WDT_CLK_PERIOD_NS    8
`define WDT_RESET_PULSE_NS   1000
`define WDT_RESET_PULSE_CYC  (`WDT_RESET_PULSE_NS / `WDT_CLK_PERIOD_NS)

`endif

// [pkg/wdt_pkg.sv]
package wdt_pkg;

  // one register bus request, all signals of one cycle
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  // sequencing around a watchdog expiry
  typedef enum logic [1:0] {
    st_idle,
    st_reset,
    st_wait_osc
  } wdt_state_e;

endpackage : wdt_pkg

// [core/count_tick_gen.sv]
`timescale 1ns/1ps
`include "wdt_defines.svh"

module count_tick_gen (
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_rc_osc,
  input  wire logic i_use_cpu_div,
  output logic      o_tick
);

  logic       rc_meta;
  logic       rc_sync;
  logic       rc_prev;
  logic [2:0] div;

  // rc oscillator is foreign to i_clk: two flops, then an edge stage
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      rc_meta <= 1'b0;
      rc_sync <= 1'b0;
      rc_prev <= 1'b0;
    end
    else
    begin
      rc_meta <= i_rc_osc;
      rc_sync <= rc_meta;
      rc_prev <= rc_sync;
    end
  end

  // cpu clock divided by six, free running
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      div <= 3'h0;
    else if (div == `WDT_CPU_DIV_LAST)
      div <= 3'h0;
    else
      div <= div + 3'h1;
  end

  // one tick per count clock from the selected source
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      o_tick <= 1'b0;
    else if (i_use_cpu_div)
      o_tick <= (div == `WDT_CPU_DIV_LAST);
    else
      o_tick <= rc_sync & ~rc_prev;
  end

endmodule : count_tick_gen

// [core/reset_pulse_gen.sv]
`timescale 1ns/1ps
`include "wdt_defines.svh"

module reset_pulse_gen (
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_start,
  output logic      o_pulse,
  output logic      o_done
);

  localparam logic [7:0] PULSE_LAST = 8'(`WDT_RESET_PULSE_CYC - 1);

  logic [7:0] cnt;

  // stretch a start strobe into a fixed-length internal reset
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      cnt     <= 8'h00;
      o_pulse <= 1'b0;
      o_done  <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      if (i_start && !o_pulse)
      begin
        o_pulse <= 1'b1;
        cnt     <= 8'h00;
      end
      else if (o_pulse)
      begin
        if (cnt == PULSE_LAST)
        begin
          o_pulse <= 1'b0;
          o_done  <= 1'b1;
        end
        else
          cnt <= cnt + 8'h01;
      end
    end
  end

  pulse_len_a:
    assert property (@(posedge i_clk) disable iff (i_reset)
      $rose(o_pulse) |-> o_pulse [*8])
    else $error("internal reset pulse ended too early");

endmodule : reset_pulse_gen

// [core/watchdog_interval_timer.sv]
`timescale 1ns/1ps
`include "wdt_defines.svh"

// How it works
// - watchdog mode counts only from the on-chip rc oscillator; software cannot stop it
// - interval mode: overflow raises an interrupt instead of a chip reset
// - rate code selects 8192 count clocks doubled per step, up to 1048576
// - watchdog mode allows one control write after each chip reset
// - a feed is 1Eh then E1h written to the feed register
// - other activity between the two feed writes is allowed
// - a wrong feed sequence changes nothing; expiry stays as scheduled
// - watchdog expiry drives an internal reset for about one microsecond
// - expiry in power-down restarts the oscillator and holds execution until stable
// - rc edges are sampled on the cpu clock i_clk, so expiry stops if the cpu clock fails
// - any other chip reset deactivates the watchdog while it lasts
// - overflow flag sets on expiry, clears on a correct feed
// - run bit starts and stops the timer; forced on in watchdog mode
// - clock bit picks cpu clock over six or rc; forced to rc in watchdog mode
// - control resets to 30h after watchdog reset, else 10h or 00h by config
// - config enable bit at one means watchdog mode; zero keeps interval use
module watchdog_interval_timer (
  input  wire logic              i_clk,
  input  wire logic              i_reset,
  input  wire logic              i_cfg_enable,
  input  wire logic              i_rc_osc,
  input  wire logic              i_other_reset,
  input  wire logic              i_power_down,
  input  wire logic              i_osc_stable,
  input  wire wdt_pkg::reg_req_s i_req,
  output logic [7:0]             o_rdata,
  output logic                   o_irq,
  output logic                   o_chip_reset,
  output logic                   o_osc_restart,
  output logic                   o_exec_hold
);

  import wdt_pkg::*;

  logic        cfg_meta;
  logic        cfg_sync;
  logic        stab_meta;
  logic        stab_sync;
  logic [1:0]  init_cnt;
  logic        init_done;
  logic [7:0]  ctrl;
  logic        wrote_once;
  logic        feed_armed;
  logic [19:0] count;
  logic [7:0]  irq_stat;
  logic [7:0]  irq_mask;
  logic        pd_latched;
  wdt_state_e  state;
  wdt_state_e  next_state;
  logic        tick;
  logic        pulse_done;
  logic        cfg_en;
  logic        run_eff;
  logic        active;
  logic        expire;
  logic        wd_expire;
  logic        ctrl_wr;
  logic        ctrl_wr_ok;
  logic        feed_wr;
  logic        feed_ok;
  logic [7:0]  irq_set;
  logic [7:0]  read_value;

  // terminal count for a rate code, minus one so the compare hits on the last tick
  function automatic logic [19:0] timeout_last(input logic [2:0] rate);
    timeout_last = (`WDT_BASE_TIMEOUT << rate) - 20'h00001;
  endfunction : timeout_last

  // config strap and oscillator-stable come from outside i_clk
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      cfg_meta  <= 1'b0;
      cfg_sync  <= 1'b0;
      stab_meta <= 1'b0;
      stab_sync <= 1'b0;
    end
    else
    begin
      cfg_meta  <= i_cfg_enable;
      cfg_sync  <= cfg_meta;
      stab_meta <= i_osc_stable;
      stab_sync <= stab_meta;
    end
  end

  // wait for the synchronised strap before taking the reset value
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      init_cnt <= 2'h0;
    else if (init_cnt != `WDT_INIT_DONE)
      init_cnt <= init_cnt + 2'h1;
  end

  assign init_done = (init_cnt == `WDT_INIT_DONE);
  assign cfg_en    = cfg_sync;

  // mode decode: watchdog mode cannot be stopped by software
  assign run_eff   = cfg_en | ctrl[`WDT_RUN_BIT];
  assign active    = init_done && !i_other_reset && (state == st_idle);
  assign expire    = active && run_eff && tick
                     && (count >= timeout_last(ctrl[`WDT_RATE_MSB:`WDT_RATE_LSB]));
  assign wd_expire = expire && cfg_en;

  // bus decode
  assign ctrl_wr    = i_req.wr && (i_req.addr == `WDT_CTRL_ADDR);
  assign ctrl_wr_ok = ctrl_wr && (!cfg_en || !wrote_once);
  assign feed_wr    = i_req.wr && (i_req.addr == `WDT_FEED_ADDR);
  assign feed_ok    = feed_wr && feed_armed
                      && (i_req.wdata == `WDT_FEED_SECOND);

  // count clock source; the cpu divider is locked out in watchdog mode
  count_tick_gen u_tick (
    .i_clk         (i_clk),
    .i_reset       (i_reset),
    .i_rc_osc      (i_rc_osc),
    .i_use_cpu_div (ctrl[`WDT_CLKSEL_BIT] & ~cfg_en),
    .o_tick        (tick)
  );

  // fixed-length internal chip reset on watchdog expiry
  reset_pulse_gen u_pulse (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_start (wd_expire),
    .o_pulse (o_chip_reset),
    .o_done  (pulse_done)
  );

  // first half of the feed stays armed across unrelated bus traffic
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      feed_armed <= 1'b0;
    else if (i_other_reset || wd_expire)
      feed_armed <= 1'b0;
    else if (feed_wr)
      feed_armed <= (i_req.wdata == `WDT_FEED_FIRST);
  end

  // timeout counter: cleared by feed, expiry and foreign resets
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      count <= 20'h00000;
    else if (!init_done || i_other_reset)
      count <= 20'h00000;
    else if (feed_ok || expire)
      count <= 20'h00000;
    else if (active && run_eff && tick)
      count <= count + 20'h00001;
  end

  // control register; a wrong feed never touches it
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      ctrl <= `WDT_CTRL_RST_DIS;
    else if (init_cnt == `WDT_INIT_LOAD || i_other_reset)
      ctrl <= cfg_en ? `WDT_CTRL_RST_EN : `WDT_CTRL_RST_DIS;
    else if (wd_expire)
      ctrl <= `WDT_CTRL_RST_WDOG;
    else
    begin
      if (ctrl_wr_ok)
      begin
        ctrl[`WDT_RATE_MSB:`WDT_RATE_LSB] <= i_req.wdata[`WDT_RATE_MSB:`WDT_RATE_LSB];
        ctrl[`WDT_CLKSEL_BIT] <= i_req.wdata[`WDT_CLKSEL_BIT] & ~cfg_en;
        ctrl[`WDT_RUN_BIT]    <= i_req.wdata[`WDT_RUN_BIT] | cfg_en;
      end
      else
      begin
        // keep the forced bits honest if the strap changes under us
        ctrl[`WDT_CLKSEL_BIT] <= ctrl[`WDT_CLKSEL_BIT] & ~cfg_en;
        ctrl[`WDT_RUN_BIT]    <= ctrl[`WDT_RUN_BIT] | cfg_en;
      end
      // overflow sets on expiry; set wins over a feed in the same cycle
      if (expire)
        ctrl[`WDT_OVF_BIT] <= 1'b1;
      else if (feed_ok)
        ctrl[`WDT_OVF_BIT] <= 1'b0;
    end
  end

  // one write per reset in watchdog mode
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      wrote_once <= 1'b0;
    else if (i_other_reset || wd_expire)
      wrote_once <= 1'b0;
    else if (ctrl_wr)
      wrote_once <= 1'b1;
  end

  // interrupt events: interval overflow and accepted feed
  always_comb
  begin
    irq_set                    = `WDT_IRQ_RST;
    irq_set[`WDT_IRQ_OVF_BIT]  = expire && !cfg_en;
    irq_set[`WDT_IRQ_FEED_BIT] = feed_ok;
  end

  // sticky status, cleared by reading it; a new event beats the clear
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      irq_stat <= `WDT_IRQ_RST;
    else if (i_req.rd && i_req.addr == `WDT_IRQ_STAT_ADDR)
      irq_stat <= irq_set;
    else
      irq_stat <= irq_stat | irq_set;
  end

  // interrupt mask, software owned
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      irq_mask <= `WDT_IRQ_RST;
    else if (i_req.wr && i_req.addr == `WDT_IRQ_MASK_ADDR)
      irq_mask <= i_req.wdata & 8'h03;
  end

  // level interrupt, registered so it lags the status by one cycle
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      o_irq <= 1'b0;
    else
      o_irq <= |(irq_stat & irq_mask);
  end

  // read mux; reserved control bits always read zero
  always_comb
  begin
    case (i_req.addr)
      `WDT_CTRL_ADDR:     read_value = ctrl & `WDT_CTRL_WMASK | (ctrl & 8'h20);
      `WDT_IRQ_STAT_ADDR: read_value = irq_stat;
      `WDT_IRQ_MASK_ADDR: read_value = irq_mask;
      default:            read_value = 8'h00;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      o_rdata <= 8'h00;
    else if (i_req.rd)
      o_rdata <= read_value;
    else
      o_rdata <= 8'h00;
  end

  // power-down state at expiry decides whether we wait for the oscillator
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      pd_latched <= 1'b0;
    else if (wd_expire)
      pd_latched <= i_power_down;
  end

  // expiry sequencing
  always_comb
  begin
    next_state = state;
    case (state)
      st_idle:
        if (wd_expire)
          next_state = st_reset;
      st_reset:
        if (pulse_done)
          next_state = pd_latched ? st_wait_osc : st_idle;
      st_wait_osc:
        if (stab_sync)
          next_state = st_idle;
      default:
        next_state = st_idle;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
      state <= st_idle;
    else
      state <= next_state;
  end

  // oscillator restart and execution hold are flops of the next state
  always_ff @(posedge i_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_osc_restart <= 1'b0;
      o_exec_hold   <= 1'b0;
    end
    else
    begin
      o_osc_restart <= (next_state == st_wait_osc);
      o_exec_hold   <= (next_state == st_wait_osc);
    end
  end

  feed_clears_cnt_a:
    assert property (@(posedge i_clk) disable iff (i_reset)
      feed_ok && !i_other_reset |=> count == 20'h00000)
    else $error("counter not cleared after a correct feed");

  run_forced_a:
    assert property (@(posedge i_clk) disable iff (i_reset)
      init_done && cfg_en && $stable(cfg_en) |=> ctrl[`WDT_RUN_BIT])
    else $error("run bit not forced on in watchdog mode");

  clk_forced_a:
    assert property (@(posedge i_clk) disable iff (i_reset)
      init_done && cfg_en && $stable(cfg_en) |=> !ctrl[`WDT_CLKSEL_BIT])
    else $error("clock select not forced to rc in watchdog mode");

  write_once_a:
    assert property (@(posedge i_clk) disable iff (i_reset)
      ctrl_wr && cfg_en && wrote_once && !i_other_reset && !wd_expire
      |=> $stable(ctrl[`WDT_RATE_MSB:`WDT_RATE_LSB]))
    else $error("second control write took effect in watchdog mode");

  wd_reset_out_a:
    assert property (@(posedge i_clk) disable iff (i_reset)
      wd_expire |=> o_chip_reset ##1 ctrl == `WDT_CTRL_RST_WDOG || i_other_reset)
    else $error("watchdog expiry did not start the internal reset");

  interval_no_reset_a:
    assert property (@(posedge i_clk) disable iff (i_reset)
      expire && !cfg_en |=> !o_chip_reset ##1 irq_stat[`WDT_IRQ_OVF_BIT])
    else $error("interval overflow reset the chip or missed its interrupt");

  ovf_on_expire_a:
    assert property (@(posedge i_clk) disable iff (i_reset)
      expire && !i_other_reset |=> ctrl[`WDT_OVF_BIT])
    else $error("overflow flag not set on expiry");

  stopped_holds_a:
    assert property (@(posedge i_clk) disable iff (i_reset)
      init_done && !run_eff && !feed_ok && !i_other_reset |=> $stable(count))
    else $error("stopped timer kept counting");

  other_reset_a:
    assert property (@(posedge i_clk) disable iff (i_reset)
      i_other_reset |=> count == 20'h00000 && !o_chip_reset[*1])
    else $error("watchdog active during a foreign reset");

  bad_feed_a:
    assert property (@(posedge i_clk) disable iff (i_reset)
      feed_wr && i_req.wdata != `WDT_FEED_FIRST && !feed_ok && !i_other_reset
      && !expire && active && run_eff && tick |=> count == $past(count) + 20'h00001)
    else $error("wrong feed disturbed the counter");

  pd_wait_a:
    assert property (@(posedge i_clk) disable iff (i_reset)
      state == st_reset && pulse_done && pd_latched && !stab_sync
      |=> o_osc_restart && o_exec_hold)
    else $error("power-down expiry did not hold execution");

endmodule : watchdog_interval_timer

// [verif/tb_top.sv]
`timescale 1ns/1ps
`include "wdt_defines.svh"

module tb_top;
  import wdt_pkg::*;

  // one row: a register write, then a read back of the same place
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } row_s;

  localparam int WDOG_CYC = 8192 * 4; // rc tick every 4 clocks, rate 0
  localparam int IVAL_CYC = 8192 * 6; // cpu clock over six, rate 0
  localparam int SLACK    = 12;       // rc sync and divider phase

  logic       i_clk;
  logic       i_reset;
  logic       i_cfg_enable;
  logic       i_rc_osc;
  logic       i_other_reset;
  logic       i_power_down;
  logic       i_osc_stable;
  reg_req_s   i_req;
  logic [7:0] o_rdata;
  logic       o_irq;
  logic       o_chip_reset;
  logic       o_osc_restart;
  logic       o_exec_hold;
  int         mismatches;
  int         num_checks;
  int         n;
  logic [7:0] rd_val;
  longint     t0;
  row_s       rows [7];

  watchdog_interval_timer u_dut (
    .i_clk         (i_clk),
    .i_reset       (i_reset),
    .i_cfg_enable  (i_cfg_enable),
    .i_rc_osc      (i_rc_osc),
    .i_other_reset (i_other_reset),
    .i_power_down  (i_power_down),
    .i_osc_stable  (i_osc_stable),
    .i_req         (i_req),
    .o_rdata       (o_rdata),
    .o_irq         (o_irq),
    .o_chip_reset  (o_chip_reset),
    .o_osc_restart (o_osc_restart),
    .o_exec_hold   (o_exec_hold)
  );

  // bench clock, 8 ns period
  always #4 i_clk = ~i_clk;

  // rc oscillator, 32 ns period; offset so its edges never meet the clock's
  initial
  begin
    i_rc_osc = 1'b0;
    #3;
    forever #16 i_rc_osc = ~i_rc_osc;
  end

  task automatic tally_and_finish();
    if (mismatches == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask : check

  // timing seen through rc sync and divider phase gets a small window
  task automatic check_time(input int got, input int exp);
    num_checks++;
    if (got < exp - SLACK || got > exp + SLACK)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask : check_time

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk);
    i_req <= '0;
  endtask : bus_wr

  // read data stand only in the cycle after the read edge
  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_clk);
    i_req <= '0;
    #1;
    check(o_rdata, exp);
  endtask : rd_check

  task automatic feed();
    bus_wr(`WDT_FEED_ADDR, `WDT_FEED_FIRST);
    bus_wr(`WDT_FEED_ADDR, `WDT_FEED_SECOND);
  endtask : feed

  function automatic logic pick(input int sel);
    case (sel)
      0:       return o_chip_reset;
      1:       return o_irq;
      2:       return ~o_exec_hold;
      default: return ~o_chip_reset;
    endcase
  endfunction : pick

  // bounded wait; running out ends the run as a failure
  task automatic wait_for(input int sel, input int lim, output int cnt);
    cnt = 0;
    do
    begin
      @(posedge i_clk);
      #1;
      cnt++;
    end while (pick(sel) !== 1'b1 && cnt < lim);
    if (pick(sel) !== 1'b1)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, pick(sel), 1'b1);
      mismatches++;
      tally_and_finish();
    end
  endtask : wait_for

  task automatic do_reset(input logic cfg);
    i_cfg_enable <= cfg;
    i_reset      <= 1'b1;
    repeat (8) @(posedge i_clk);
    i_reset <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask : do_reset

  initial
  begin
    i_clk         = 1'b0;
    i_reset       = 1'b1;
    i_cfg_enable  = 1'b0;
    i_other_reset = 1'b0;
    i_power_down  = 1'b0;
    i_osc_stable  = 1'b1;
    i_req         = '0;
    mismatches    = 0;
    num_checks    = 0;
    rows[0] = '{8'hA7, 8'h25, 8'h05}; // reserved bits kept zero by software
    rows[1] = '{8'hA7, 8'h3F, 8'h1F}; // overflow bit not writable
    rows[2] = '{8'hA7, 8'h00, 8'h00};
    rows[3] = '{8'hA9, 8'h03, 8'h03};
    rows[4] = '{8'hA6, 8'h55, 8'h00}; // feed place reads zero
    rows[5] = '{8'hB0, 8'h5A, 8'h00}; // unmapped
    rows[6] = '{8'hA9, 8'h02, 8'h02};

    // interval mode: reset values, then the register rows
    do_reset(1'b0);
    rd_check(`WDT_CTRL_ADDR, `WDT_CTRL_RST_DIS);
    rd_check(`WDT_IRQ_STAT_ADDR, `WDT_IRQ_RST);
    rd_check(`WDT_IRQ_MASK_ADDR, `WDT_IRQ_RST);
    foreach (rows[i])
    begin
      bus_wr(rows[i].addr, rows[i].wdata);
      rd_check(rows[i].addr, rows[i].exp);
    end

    // broken feed sequences leave no trace
    bus_wr(`WDT_FEED_ADDR, `WDT_FEED_SECOND);
    rd_check(`WDT_IRQ_STAT_ADDR, 8'h00);
    bus_wr(`WDT_FEED_ADDR, `WDT_FEED_FIRST);
    bus_wr(`WDT_FEED_ADDR, 8'h55);
    bus_wr(`WDT_FEED_ADDR, `WDT_FEED_SECOND);
    rd_check(`WDT_IRQ_STAT_ADDR, 8'h00);
    // a feed with other traffic between its halves still counts
    bus_wr(`WDT_FEED_ADDR, `WDT_FEED_FIRST);
    rd_check(`WDT_CTRL_ADDR, 8'h00);
    bus_wr(`WDT_IRQ_MASK_ADDR, 8'h02);
    bus_wr(`WDT_FEED_ADDR, `WDT_FEED_SECOND);
    repeat (2) @(posedge i_clk);
    #1;
    check({7'h00, o_irq}, 8'h01);
    rd_check(`WDT_IRQ_STAT_ADDR, 8'h02);
    repeat (2) @(posedge i_clk);
    #1;
    check({7'h00, o_irq}, 8'h00);

    // interval overflow on cpu clock over six, rate 0
    bus_wr(`WDT_IRQ_MASK_ADDR, 8'h01);
    bus_wr(`WDT_CTRL_ADDR, 8'h18);
    feed();
    wait_for(1, IVAL_CYC + 100, n);
    check_time(n, IVAL_CYC);
    check({7'h00, o_chip_reset}, 8'h00);
    rd_check(`WDT_CTRL_ADDR, 8'h38);
    bus_wr(`WDT_IRQ_MASK_ADDR, 8'h00);
    repeat (2) @(posedge i_clk);
    #1;
    check({7'h00, o_irq}, 8'h00);
    bus_wr(`WDT_IRQ_MASK_ADDR, 8'h01);
    repeat (2) @(posedge i_clk);
    #1;
    check({7'h00, o_irq}, 8'h01);
    rd_check(`WDT_IRQ_STAT_ADDR, 8'h03);
    repeat (2) @(posedge i_clk);
    #1;
    check({7'h00, o_irq}, 8'h00);
    feed();
    rd_check(`WDT_CTRL_ADDR, 8'h18);

    // watchdog mode: forced bits and the single control write
    do_reset(1'b1);
    rd_check(`WDT_CTRL_ADDR, `WDT_CTRL_RST_EN);
    feed();
    bus_wr(`WDT_CTRL_ADDR, 8'h08);
    rd_check(`WDT_CTRL_ADDR, 8'h10);
    bus_wr(`WDT_CTRL_ADDR, 8'h07);
    rd_check(`WDT_CTRL_ADDR, 8'h10);
    // a late feed restarts the period; a wrong one later does not
    repeat (4000) @(posedge i_clk);
    feed();
    t0 = $time;
    repeat (8000) @(posedge i_clk);
    bus_wr(`WDT_FEED_ADDR, `WDT_FEED_FIRST);
    bus_wr(`WDT_FEED_ADDR, 8'h55);
    bus_wr(`WDT_FEED_ADDR, `WDT_FEED_SECOND);
    i_power_down <= 1'b1;
    i_osc_stable <= 1'b0;
    wait_for(0, WDOG_CYC, n);
    check_time(int'(($time - t0) / 8), WDOG_CYC);
    wait_for(3, 300, n);
    check(8'(n), 8'(`WDT_RESET_PULSE_CYC));
    @(posedge i_clk);
    #1;
    check({6'h00, o_osc_restart, o_exec_hold}, 8'h03);
    i_osc_stable <= 1'b1;
    wait_for(2, 10, n);
    check({6'h00, o_osc_restart, o_exec_hold}, 8'h00);
    i_power_down <= 1'b0;
    rd_check(`WDT_CTRL_ADDR, `WDT_CTRL_RST_WDOG);
    feed();
    rd_check(`WDT_CTRL_ADDR, 8'h10);

    // reset from another source reloads control; the one write, unused since the watchdog reset, then takes effect
    @(posedge i_clk);
    i_other_reset <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_other_reset <= 1'b0;
    repeat (2) @(posedge i_clk);
    rd_check(`WDT_CTRL_ADDR, `WDT_CTRL_RST_EN);
    bus_wr(`WDT_CTRL_ADDR, 8'h0B);
    rd_check(`WDT_CTRL_ADDR, 8'h13);
    check({7'h00, o_chip_reset}, 8'h00);
    tally_and_finish();
  end

endmodule : tb_top
